// *** shared/emergency_run_pkg.sv ***
// Constants, codes and carrier types of the emergency-run supervisor
package emergency_run_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OPT_OFS   = 8'h00;
  localparam logic [7:0] ERUN_CFG_OFS   = 8'h04;
  localparam logic [7:0] AUTORST_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS    = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS     = 8'h18;
  localparam logic [7:0] TEMP_ALARM_OFS = 8'h1C;
  localparam logic [7:0] TEMP_FAULT_OFS = 8'h20;

  // Reset values
  localparam logic [3:0] CTRL_OPT_RST   = 4'hB;
  localparam logic [2:0] ERUN_CFG_RST   = 3'h0;
  localparam logic       AUTORST_RST    = 1'h0;
  localparam logic [3:0] IRQ_EN_RST     = 4'h0;
  localparam logic [7:0] TEMP_ALARM_RST = 8'h50;
  localparam logic [7:0] TEMP_FAULT_RST = 8'h64;

  // Emergency-run configuration codes
  localparam logic [2:0] ERUN_OFF    = 3'h0;
  localparam logic [2:0] ERUN_KEEP   = 3'h1;
  localparam logic [2:0] ERUN_MAXSPD = 3'h2;
  localparam logic [2:0] ERUN_COAST  = 3'h4;

  // Control option bit positions
  localparam int OPT_SLIP_REGEN = 0;
  localparam int OPT_DEADTIME   = 1;
  localparam int OPT_STABILIZE  = 2;
  localparam int OPT_TEMP_FREQ  = 3;

  // Interrupt bit positions
  localparam int IRQ_W     = 4;
  localparam int IRQ_ENTRY = 0;
  localparam int IRQ_EXIT  = 1;
  localparam int IRQ_CRIT  = 2;
  localparam int IRQ_ACK   = 3;

  // Status bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_ALARM  = 1;
  localparam int ST_EVER   = 2;
  localparam int ST_OVTRIP = 3;
  localparam int ST_OCTRIP = 4;
  localparam int ST_OTHER  = 5;

  // Timing
  localparam int CLK_HZ            = 40000000;
  localparam int AUTORESET_TIME_MS = 1000;
  localparam int AUTORESET_CYCLES  = CLK_HZ / 1000 * AUTORESET_TIME_MS;

  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b01,
    MODE_EMERGENCY = 2'b10
  } mode_e;

  // Fault detections from the protection logic
  typedef struct packed {
    logic overvoltage;
    logic overcurrent;
    logic other;
  } fault_in_s;

  // Compensation enables toward the motor-control core
  typedef struct packed {
    logic slipCompOn;
    logic deadTimeOn;
    logic stabilizeOn;
  } comp_ctrl_s;

endpackage

// *** design/emergency_run_supervisor.sv ***
// Emergency-run supervisor: override mode, critical fault reset, control options
// What this block does
// (RULE1) Enter emergency run when the input pin is low and config enables it.
// (RULE2) Suppress ordinary fault detections while emergency run is active.
// (RULE3) Config 0 keeps the function off; code 3 enables nothing.
// (RULE4) Config 1: raise alarm, leave speed reference and control unchanged.
// (RULE5) Config 2: raise alarm, force speed reference to maximum speed.
// (RULE6) Config 4: raise alarm, disable output pulses so motor coasts.
// (RULE7) Keypad acknowledge clears alarm display; status still reports emergency run.
// (RULE8) Indicator output is high while emergency run is active.
// (RULE9) Ignore every stop command, general enable removal included, in emergency run.
// (RULE10) Keep detecting DC-link overvoltage and overcurrent faults in emergency run.
// (RULE11) Auto-reset select 0: critical faults reset per general auto-reset.
// (RULE12) Auto-reset select 1: in emergency run, reset each critical fault 1s after detection.
// (RULE13) Keep a persistent record that emergency run has occurred.
// (RULE14) Option bit 0 clear turns slip compensation off during regeneration.
// (RULE15) Option bit 1 enables dead-time compensation.
// (RULE16) Option bit 2 enables output current stabilization.
// (RULE17) Option bit 3 reduces switching frequency between alarm and fault temperature.
// (RULE18) Current-reading frequency reduction wins over temperature reduction.
// (RULE19) Leave emergency run when the input pin returns high.
`timescale 1ns/1ps
module emergency_run_supervisor #(
  parameter logic [25:0] AutoresetCycles = 26'(emergency_run_pkg::AUTORESET_CYCLES)
) (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          emergencyInputTerminal,
  input  wire logic                          keypadAckKey,
  input  wire logic                          generalEnable,
  input  wire logic                          stopCommand,
  input  wire emergency_run_pkg::fault_in_s  faultIn,
  input  wire logic                          generalAutoresetGrant,
  input  wire logic                          regenActive,
  input  wire logic [15:0]                   speedRefIn,
  input  wire logic [15:0]                   maximumSpeedLimit,
  input  wire logic [7:0]                    temperature,
  input  wire logic                          currentReadReduceReq,
  input  wire logic [7:0]                    currentReadLevel,
  output logic                               emergencyIndicatorOutput,
  output logic                               emergencyRunAlarm,
  output logic                               runCommand,
  output logic                               pulseDisable,
  output logic [15:0]                        speedRefOut,
  output logic                               faultSuppress,
  output logic                               driveTrip,
  output emergency_run_pkg::comp_ctrl_s      compCtrl,
  output logic                               freqReduceFromCurrent,
  output logic [7:0]                         freqReduceLevel,
  output logic [7:0]                         freqReduceSpan,
  output logic                               irq
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic [3:0]                      ctrlOpt_q;
  logic [2:0]                      erunCfg_q;
  logic                            autorst_q;
  logic [emergency_run_pkg::IRQ_W-1:0] irqStat_q;
  logic [emergency_run_pkg::IRQ_W-1:0] irqEn_q;
  logic [7:0]                      tempAlarm_q;
  logic [7:0]                      tempFault_q;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [31:0]                     prdata_q;
  logic [2:0]                      pinSync_q;
  logic                            pinLevel_q;
  logic [2:0]                      keySync_q;
  logic                            keyLevel_q;
  logic                            keyPrev_q;
  emergency_run_pkg::mode_e        mode_q;
  logic                            alarm_q;
  logic                            everRan_q;
  logic [1:0]                      critTrip_q;
  logic                            otherTrip_q;
  logic                            indicator_q;
  logic                            run_q;
  logic                            pulseOff_q;
  logic [15:0]                     speedRef_q;
  logic                            suppress_q;
  logic                            trip_q;
  emergency_run_pkg::comp_ctrl_s   comp_q;
  logic                            fromCurrent_q;
  logic [7:0]                      reduceLevel_q;
  logic [7:0]                      reduceSpan_q;
  logic                            irq_q;
  logic                            wrEn;
  logic                            rdSetup;
  logic                            addrHit;
  logic                            cfgValid;
  logic                            wantEmerg;
  logic                            emergActive;
  logic                            entering;
  logic                            leaving;
  logic                            keyPress;
  logic                            useUnlimited;
  logic [1:0]                      critFault;
  logic [1:0]                      critReset;
  logic [1:0]                      timerDone;
  logic [emergency_run_pkg::IRQ_W-1:0] irqEvent;
  logic [emergency_run_pkg::IRQ_W-1:0] irqClr;

  // APB strobes; the slave answers in the first access cycle
  assign wrEn    = psel && penable && pwrite && pready_q;
  assign rdSetup = psel && !penable;
  always_comb begin
    unique case (paddr)
      emergency_run_pkg::CTRL_OPT_OFS,
      emergency_run_pkg::ERUN_CFG_OFS,
      emergency_run_pkg::AUTORST_OFS,
      emergency_run_pkg::STATUS_OFS,
      emergency_run_pkg::IRQ_STAT_OFS,
      emergency_run_pkg::IRQ_CLR_OFS,
      emergency_run_pkg::IRQ_EN_OFS,
      emergency_run_pkg::TEMP_ALARM_OFS,
      emergency_run_pkg::TEMP_FAULT_OFS: addrHit = 1'b1;
      default:                           addrHit = 1'b0;
    endcase
  end

  // Ready and error for one cycle after setup
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= rdSetup;
      pslverr_q <= rdSetup && !addrHit;
    end
  end

  // Read data captured at setup so it is stable through the access phase
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        emergency_run_pkg::CTRL_OPT_OFS:   prdata_q[3:0] <= ctrlOpt_q;
        emergency_run_pkg::ERUN_CFG_OFS:   prdata_q[2:0] <= erunCfg_q;
        emergency_run_pkg::AUTORST_OFS:    prdata_q[0]   <= autorst_q;
        emergency_run_pkg::STATUS_OFS:     prdata_q[5:0] <= {otherTrip_q, critTrip_q[1], critTrip_q[0],
                                                             everRan_q, alarm_q, emergActive};
        emergency_run_pkg::IRQ_STAT_OFS:   prdata_q[3:0] <= irqStat_q;
        emergency_run_pkg::IRQ_EN_OFS:     prdata_q[3:0] <= irqEn_q;
        emergency_run_pkg::TEMP_ALARM_OFS: prdata_q[7:0] <= tempAlarm_q;
        emergency_run_pkg::TEMP_FAULT_OFS: prdata_q[7:0] <= tempFault_q;
        default:                           prdata_q      <= 32'h0000_0000;
      endcase
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrlOpt_q   <= emergency_run_pkg::CTRL_OPT_RST;
      erunCfg_q   <= emergency_run_pkg::ERUN_CFG_RST;
      autorst_q   <= emergency_run_pkg::AUTORST_RST;
      irqEn_q     <= emergency_run_pkg::IRQ_EN_RST;
      tempAlarm_q <= emergency_run_pkg::TEMP_ALARM_RST;
      tempFault_q <= emergency_run_pkg::TEMP_FAULT_RST;
    end else if (wrEn) begin
      unique case (paddr)
        emergency_run_pkg::CTRL_OPT_OFS:   ctrlOpt_q   <= pwdata[3:0];
        emergency_run_pkg::ERUN_CFG_OFS:   erunCfg_q   <= pwdata[2:0];
        emergency_run_pkg::AUTORST_OFS:    autorst_q   <= pwdata[0];
        emergency_run_pkg::IRQ_EN_OFS:     irqEn_q     <= pwdata[3:0];
        emergency_run_pkg::TEMP_ALARM_OFS: tempAlarm_q <= pwdata[7:0];
        emergency_run_pkg::TEMP_FAULT_OFS: tempFault_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pinSync_q  <= 3'h7;
      pinLevel_q <= 1'b1;
      keySync_q  <= 3'h0;
      keyLevel_q <= 1'b0;
      keyPrev_q  <= 1'b0;
    end else begin
      pinSync_q <= {pinSync_q[1:0], emergencyInputTerminal};
      keySync_q <= {keySync_q[1:0], keypadAckKey};
      if (pinSync_q[1] == pinSync_q[2]) begin
        pinLevel_q <= pinSync_q[2];
      end
      if (keySync_q[1] == keySync_q[2]) begin
        keyLevel_q <= keySync_q[2];
      end
      keyPrev_q <= keyLevel_q;
    end
  end
  assign keyPress = keyLevel_q && !keyPrev_q;

  // (RULE3) Only codes 1, 2, 4 enable
  assign cfgValid = (erunCfg_q == emergency_run_pkg::ERUN_KEEP) ||
                    (erunCfg_q == emergency_run_pkg::ERUN_MAXSPD) ||
                    (erunCfg_q == emergency_run_pkg::ERUN_COAST);
  // (RULE1) Active-low input request
  assign wantEmerg   = !pinLevel_q && cfgValid;
  assign emergActive = (mode_q == emergency_run_pkg::MODE_EMERGENCY);
  assign entering    = !emergActive && wantEmerg;
  assign leaving     = emergActive && !wantEmerg;

  // Mode sequencer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_q <= emergency_run_pkg::MODE_NORMAL;
    end else begin
      unique case (mode_q)
        emergency_run_pkg::MODE_NORMAL: begin
          // (RULE1) Enter on request
          if (wantEmerg) begin
            mode_q <= emergency_run_pkg::MODE_EMERGENCY;
          end
        end
        emergency_run_pkg::MODE_EMERGENCY: begin
          // (RULE19) Leave on pin high
          if (!wantEmerg) begin
            mode_q <= emergency_run_pkg::MODE_NORMAL;
          end
        end
        default: mode_q <= emergency_run_pkg::MODE_NORMAL;
      endcase
    end
  end

  // Alarm display and persistent record; entry wins over acknowledge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alarm_q   <= 1'b0;
      everRan_q <= 1'b0;
    end else begin
      // (RULE4) Alarm raised on entry
      if (entering) begin
        alarm_q <= 1'b1;
      // (RULE7) Acknowledge clears display
      end else if (keyPress || leaving) begin
        alarm_q <= 1'b0;
      end
      // (RULE13) Sticky record of use
      if (entering) begin
        everRan_q <= 1'b1;
      end
    end
  end

  // Critical faults: each has its own unlimited auto-reset timer
  assign critFault    = {faultIn.overcurrent, faultIn.overvoltage};
  assign useUnlimited = emergActive && autorst_q;
  for (genvar i = 0; i < 2; i++) begin : g_crit
    logic [25:0] timer_q;
    // (RULE12) One-second reset timer
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        timer_q <= 26'h000_0000;
      end else if (!critTrip_q[i] || !useUnlimited || timerDone[i]) begin
        timer_q <= 26'h000_0000;
      end else begin
        timer_q <= timer_q + 26'h000_0001;
      end
    end
    assign timerDone[i] = critTrip_q[i] && (timer_q == AutoresetCycles - 26'h000_0001);
    // (RULE11) General grant when not unlimited
    assign critReset[i] = useUnlimited ? timerDone[i] : generalAutoresetGrant;
    // (RULE10) Detection kept in every mode
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        critTrip_q[i] <= 1'b0;
      end else if (critFault[i]) begin
        critTrip_q[i] <= 1'b1;
      end else if (critReset[i]) begin
        critTrip_q[i] <= 1'b0;
      end
    end
  end

  // (RULE2) Ordinary faults ignored in emergency run
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      otherTrip_q <= 1'b0;
    end else if (faultIn.other && !emergActive) begin
      otherTrip_q <= 1'b1;
    end else if (generalAutoresetGrant) begin
      otherTrip_q <= 1'b0;
    end
  end

  // Drive commands toward the power stage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      indicator_q <= 1'b0;
      run_q       <= 1'b0;
      pulseOff_q  <= 1'b1;
      speedRef_q  <= 16'h0000;
      suppress_q  <= 1'b0;
      trip_q      <= 1'b0;
    end else begin
      // (RULE8) Indicator follows mode
      indicator_q <= emergActive;
      // (RULE9) Stop commands ignored
      run_q       <= emergActive || (generalEnable && !stopCommand);
      // (RULE6) Coast by pulse cut
      pulseOff_q  <= (|critTrip_q) || otherTrip_q ||
                     (emergActive && erunCfg_q == emergency_run_pkg::ERUN_COAST);
      // (RULE5) Maximum speed forced
      if (emergActive && erunCfg_q == emergency_run_pkg::ERUN_MAXSPD) begin
        speedRef_q <= maximumSpeedLimit;
      // (RULE4) Reference left unchanged
      end else begin
        speedRef_q <= speedRefIn;
      end
      suppress_q  <= emergActive;
      trip_q      <= (|critTrip_q) || otherTrip_q;
    end
  end

  // Compensation enables and switching-frequency reduction
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      comp_q        <= '0;
      fromCurrent_q <= 1'b0;
      reduceLevel_q <= 8'h00;
      reduceSpan_q  <= 8'h00;
    end else begin
      // (RULE14) Slip comp in regeneration
      comp_q.slipCompOn  <= !regenActive || ctrlOpt_q[emergency_run_pkg::OPT_SLIP_REGEN];
      // (RULE15) Dead-time compensation enable
      comp_q.deadTimeOn  <= ctrlOpt_q[emergency_run_pkg::OPT_DEADTIME];
      // (RULE16) Current stabilization enable
      comp_q.stabilizeOn <= ctrlOpt_q[emergency_run_pkg::OPT_STABILIZE];
      reduceSpan_q       <= tempFault_q - tempAlarm_q;
      fromCurrent_q      <= currentReadReduceReq;
      // (RULE18) Current reading has priority
      if (currentReadReduceReq) begin
        reduceLevel_q <= currentReadLevel;
      // (RULE17) Proportional thermal reduction
      end else if (ctrlOpt_q[emergency_run_pkg::OPT_TEMP_FREQ] && temperature > tempAlarm_q) begin
        reduceLevel_q <= (temperature >= tempFault_q) ? tempFault_q - tempAlarm_q
                                                      : temperature - tempAlarm_q;
      end else begin
        reduceLevel_q <= 8'h00;
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle
  assign irqEvent = {keyPress, |(critFault & ~critTrip_q), leaving, entering};
  assign irqClr   = (wrEn && paddr == emergency_run_pkg::IRQ_CLR_OFS) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irqStat_q <= 4'h0;
      irq_q     <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvent;
      irq_q     <= |(irqStat_q & irqEn_q);
    end
  end

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign emergencyIndicatorOutput = indicator_q;
  assign emergencyRunAlarm        = alarm_q;
  assign runCommand               = run_q;
  assign pulseDisable             = pulseOff_q;
  assign speedRefOut              = speedRef_q;
  assign faultSuppress            = suppress_q;
  assign driveTrip                = trip_q;
  assign compCtrl                 = comp_q;
  assign freqReduceFromCurrent    = fromCurrent_q;
  assign freqReduceLevel          = reduceLevel_q;
  assign freqReduceSpan           = reduceSpan_q;
  assign irq                      = irq_q;

  // Checks next to the mode logic
  mode_entry_a: assert property (entering |=> emergActive ##1 indicator_q) // RULE1
    else $error("emergency entry missed");
  cfg_off_a: assert property (!cfgValid |=> !emergActive) // RULE3
    else $error("disabled config entered emergency");
  alarm_raise_a: assert property (entering |=> alarm_q && everRan_q) // RULE4
    else $error("alarm not raised on entry");
  max_speed_a: assert property (emergActive && erunCfg_q == emergency_run_pkg::ERUN_MAXSPD
                                |=> speedRef_q == $past(maximumSpeedLimit)) // RULE5
    else $error("speed not forced to maximum");
  coast_cut_a: assert property (emergActive && erunCfg_q == emergency_run_pkg::ERUN_COAST
                                |=> pulseDisable) // RULE6
    else $error("pulses not cut");
  ack_clear_a: assert property (keyPress && !entering && emergActive && wantEmerg
                                |=> !alarm_q && emergActive) // RULE7
    else $error("acknowledge failed");
  stop_ignored_a: assert property (emergActive && $past(emergActive) |-> run_q) // RULE9
    else $error("stop honoured in emergency");
  crit_detect_a: assert property (critFault[0] |=> critTrip_q[0] ##1 trip_q) // RULE10
    else $error("overvoltage not latched");
  other_mask_a: assert property (emergActive && !otherTrip_q |=> !otherTrip_q) // RULE2
    else $error("ordinary fault not suppressed");
  timer_reset_a: assert property (timerDone[1] && useUnlimited && !critFault[1]
                                  |=> !critTrip_q[1]) // RULE12
    else $error("unlimited reset missed");
  mode_exit_a: assert property (emergActive && pinLevel_q |=> !emergActive ##1 !indicator_q) // RULE19
    else $error("emergency exit missed");
  freq_priority_a: assert property (currentReadReduceReq
                                    |=> fromCurrent_q && reduceLevel_q == $past(currentReadLevel)) // RULE18
    else $error("current reduction lost priority");
  cov_max_speed: cover property (entering && erunCfg_q == emergency_run_pkg::ERUN_MAXSPD);
  cov_ack: cover property (alarm_q ##1 !alarm_q && emergActive);
  cov_unlimited: cover property (timerDone[0] && useUnlimited);

endmodule

// *** dv/drive_terminal_model.sv ***
// Terminal and keypad model driving the supervisor's pins
`timescale 1ns/1ps
module drive_terminal_model (
  input  wire logic clk_sys,
  input  wire logic emergencyReq,
  input  wire logic ackReq,
  output logic      emergencyInputTerminal,
  output logic      keypadAckKey
);
  // Idle levels: input pin high, key released
  initial begin
    emergencyInputTerminal = 1'b1;
    keypadAckKey = 1'b0;
  end
  always @(posedge clk_sys) begin
    emergencyInputTerminal <= ~emergencyReq;
    keypadAckKey <= ackReq;
  end
endmodule

// *** dv/tb_emergency_run_supervisor.sv ***
// Self-checking bench for the emergency-run supervisor
`timescale 1ns/1ps
module tb_emergency_run_supervisor;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, emReq = 1'b0, ackReq = 1'b0;
  logic generalEnable = 1'b1, stopCommand = 1'b0, grant = 1'b0, regenActive = 1'b0, curReq = 1'b0;
  logic [7:0] paddr = 8'h00, temperature = 8'h20, currentReadLevel = 8'h00, lvl, span;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] speedRefIn = 16'h1234, maxSpd = 16'hABCD, speedRefOut;
  logic pready, pslverr, errSeen, emergencyInputTerminal, keypadAckKey;
  logic ind, alarm, runCmd, pulseDis, supp, trip, fromCur, irq;
  logic [2:0] cfgs [5] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h4};
  emergency_run_pkg::fault_in_s  faultIn = '0;
  emergency_run_pkg::comp_ctrl_s compCtrl;
  int bad_count = 0, samples_checked = 0;

  // Free-running system clock, 25 ns
  always #12.5 clk_sys = ~clk_sys;

  // Short auto-reset count keeps the run brief
  emergency_run_supervisor #(.AutoresetCycles(26'h14)) emergency_run_supervisor_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .faultIn(faultIn),
    .emergencyInputTerminal(emergencyInputTerminal), .keypadAckKey(keypadAckKey), .generalEnable(generalEnable),
    .stopCommand(stopCommand), .generalAutoresetGrant(grant), .regenActive(regenActive),
    .speedRefIn(speedRefIn), .maximumSpeedLimit(maxSpd), .temperature(temperature), .currentReadReduceReq(curReq),
    .currentReadLevel(currentReadLevel), .emergencyIndicatorOutput(ind), .emergencyRunAlarm(alarm),
    .runCommand(runCmd), .pulseDisable(pulseDis), .speedRefOut(speedRefOut), .faultSuppress(supp),
    .driveTrip(trip), .compCtrl(compCtrl), .freqReduceFromCurrent(fromCur), .freqReduceLevel(lvl),
    .freqReduceSpan(span), .irq(irq));

  drive_terminal_model drive_terminal_model_i (
    .clk_sys(clk_sys), .emergencyReq(emReq), .ackReq(ackReq),
    .emergencyInputTerminal(emergencyInputTerminal), .keypadAckKey(keypadAckKey));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait on an output level; a hang ends the run
  task automatic waitSig(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      summarize();
    end
  endtask

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Reset values and an unmapped address
  task automatic t_regs();
    logic [7:0] ofs [5] = '{emergency_run_pkg::CTRL_OPT_OFS, emergency_run_pkg::ERUN_CFG_OFS,
                            emergency_run_pkg::AUTORST_OFS, emergency_run_pkg::IRQ_EN_OFS, 8'h40};
    logic [31:0] exp [5] = '{32'hB, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, exp[i]);
    end
    chk(errSeen, 1'b1);
    chk(compCtrl, 3'b110);
    $display("t_regs done");
  endtask

  // Compensation gates and switching-frequency reduction
  task automatic t_opts();
    regenActive <= 1'b1;
    apb(1'b1, emergency_run_pkg::CTRL_OPT_OFS, 32'h4);
    repeat (2) @(posedge clk_sys);
    chk(compCtrl, 3'b001);
    apb(1'b1, emergency_run_pkg::CTRL_OPT_OFS, 32'hF);
    temperature <= 8'h5A;
    repeat (3) @(posedge clk_sys);
    chk(compCtrl, 3'b111);
    chk({lvl, span}, 16'h0A14);
    curReq <= 1'b1;
    currentReadLevel <= 8'h07;
    repeat (3) @(posedge clk_sys);
    chk({fromCur, lvl}, 9'h107);
    curReq <= 1'b0;
    regenActive <= 1'b0;
    $display("t_opts done");
  endtask

  // Entry with one config code while stop is commanded, then exit
  task automatic t_mode(input logic [2:0] cfg);
    logic on;
    on = (cfg == 3'h1 || cfg == 3'h2 || cfg == 3'h4);
    apb(1'b1, emergency_run_pkg::ERUN_CFG_OFS, {29'h0, cfg});
    stopCommand <= 1'b1;
    generalEnable <= 1'b0;
    emReq <= 1'b1;
    if (on) waitSig(ind, 1'b1);
    else repeat (12) @(posedge clk_sys);
    chk({ind, alarm, runCmd, supp}, {4{on}});
    if (on) begin
      chk(speedRefOut, (cfg == 3'h2) ? maxSpd : speedRefIn);
      chk(pulseDis, cfg == 3'h4);
    end
    emReq <= 1'b0;
    if (on) begin
      waitSig(ind, 1'b0);
      chk({runCmd, supp}, 2'b00);
      apb(1'b0, emergency_run_pkg::STATUS_OFS, 32'h0);
      chk(rd[2:0], 3'b100);
    end
    stopCommand <= 1'b0;
    generalEnable <= 1'b1;
    repeat (8) @(posedge clk_sys);
    $display("t_mode done cfg=%0d", cfg);
  endtask

  // Acknowledge, interrupt mask and clear, then critical fault auto-reset
  task automatic t_ack_auto();
    // Earlier runs left entry and exit bits pending; start from a clean status
    apb(1'b1, emergency_run_pkg::IRQ_CLR_OFS, 32'hF);
    apb(1'b1, emergency_run_pkg::IRQ_EN_OFS, 32'h9);
    apb(1'b1, emergency_run_pkg::ERUN_CFG_OFS, 32'h1);
    apb(1'b1, emergency_run_pkg::AUTORST_OFS, 32'h1);
    emReq <= 1'b1;
    waitSig(irq, 1'b1);
    ackReq <= 1'b1;
    waitSig(alarm, 1'b0);
    ackReq <= 1'b0;
    apb(1'b0, emergency_run_pkg::STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'b01);
    apb(1'b0, emergency_run_pkg::IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h9);
    apb(1'b1, emergency_run_pkg::IRQ_EN_OFS, 32'h0);
    // Interrupt output lags the enable by one edge
    @(posedge clk_sys);
    chk(irq, 1'b0);
    apb(1'b1, emergency_run_pkg::IRQ_CLR_OFS, 32'hF);
    apb(1'b0, emergency_run_pkg::IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    faultIn.overvoltage <= 1'b1;
    faultIn.overcurrent <= 1'b1;
    @(posedge clk_sys);
    faultIn.overvoltage <= 1'b0;
    faultIn.overcurrent <= 1'b0;
    waitSig(trip, 1'b1);
    repeat (10) @(posedge clk_sys);
    chk(trip, 1'b1);
    waitSig(trip, 1'b0);
    faultIn.other <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(trip, 1'b0);
    faultIn.other <= 1'b0;
    // Limited select: only the general grant releases a critical trip
    apb(1'b1, emergency_run_pkg::AUTORST_OFS, 32'h0);
    faultIn.overvoltage <= 1'b1;
    repeat (25) @(posedge clk_sys);
    chk(trip, 1'b1);
    faultIn.overvoltage <= 1'b0;
    grant <= 1'b1;
    waitSig(trip, 1'b0);
    grant <= 1'b0;
    emReq <= 1'b0;
    waitSig(ind, 1'b0);
    $display("t_ack_auto done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_opts();
    for (int i = 0; i < 5; i++) t_mode(cfgs[i]);
    t_ack_auto();
    summarize();
  end
endmodule
